/* hw/lfs_supervisor.sv */
// Behaviour
// - input UV: drives off after filter, flag
// - input OV: drives off at once, flag
// - regulator UV: drives off at once, flag
// - drive supply UV: all four drives off
// - current limit over 64 cycles: hiccup
// - thermal: drive supply and driver off
// - output OV: stop switching, select picks hiccup
// - overcurrent after filter cycles: off, hiccup
// - LED short/UV: flag after 30 cycles
// - dimming UV: open dimming switch only
// - open LED behaves like output OV
// - high-beam fault latches, low beam, clearable
// - frequency pin fault: flag, default oscillator
// - string short: off after two cycles, hiccup
// - start only once enable input is high
// - enable tied high: start after input UV
// - overcurrent filter code picks 2/4/8/16
// - UV masked startup plus 50 ms, dimming open
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`default_nettype none
module lfs_supervisor import lfs_pkg::*; #(
	parameter int unsigned HICCUP_CYCLES = 200000,
	parameter int unsigned SOFTSTART_CYCLES = 4000,
	parameter int unsigned STARTUP_MASK_CYCLES = LFS_STARTUP_MASK_CYCLES,
	parameter int unsigned UV_FILTER_CYCLES = 20
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// analog and control inputs
	input wire lfs_fault_type flt,
	input wire logic en_pwm,
	input wire logic beam_request,
	input wire logic sw_cycle,
	// power stage, flag and interrupt outputs
	output lfs_drive_type drv,
	output logic primary_fault_flag_n,
	output logic secondary_fault_flag_n,
	output logic osc_default_sel,
	output logic low_beam_mode,
	output logic linear_regulator_enable,
	output logic irq,
	// axi4-lite write
	input wire logic [LFS_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [LFS_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// overcurrent filter code to allowed cycles
	function automatic logic [LFS_CW-1:0] oc_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: oc_cycles = LFS_OC_C0;
			2'h1: oc_cycles = LFS_OC_C1;
			2'h2: oc_cycles = LFS_OC_C2;
			2'h3: oc_cycles = LFS_OC_C3;
		endcase
	endfunction

	// byte enables to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	lfs_state_type st_q, st_d;
	logic [LFS_TW-1:0] tmr_q, tmr_d;
	logic [LFS_UVW-1:0] uvf_q, uvf_d;
	logic hbf_q, hbf_d, hbf_clr;
	lfs_drive_type drv_q, drv_d;
	logic ff1_n_q, ff1_n_d, ff2_n_q, ff2_n_d;
	logic osc_q, osc_d, lowb_q, lowb_d;
	logic [LFS_CFG_W-1:0] cfg_q, cfg_d;
	logic [LFS_NFLT-1:0] stat_q, stat_d, mask_q, mask_d, prev_q, evt;
	logic irq_q, irq_d;
	logic [LFS_NCH-1:0] cond, trip;
	logic [LFS_CW-1:0] thr [LFS_NCH];
	logic vin_uv_f, sup, active, ovstop, uv_mask, hic_trip, oneout_stop, sw_on, ff_any;

	// input UV filter delay, counted in clock cycles
	always_comb begin
		uvf_d = uvf_q;
		if (!flt.vin_uv) begin
			uvf_d = '0;
		end else if (uvf_q != LFS_UVW'(UV_FILTER_CYCLES)) begin
			uvf_d = uvf_q + 1'b1;
		end
	end
	assign vin_uv_f = flt.vin_uv && (uvf_q == LFS_UVW'(UV_FILTER_CYCLES));

	// faults that stop the whole driver and wait for recovery
	assign sup = vin_uv_f | flt.vin_ov | flt.internal_regulator_output_uv | flt.gate_drive_supply_uv | flt.thermal_shutdown_level;
	assign active = (st_q == LFS_SOFTSTART) || (st_q == LFS_RUN);
	assign ovstop = flt.out_ov | flt.open_led;
	// short/UV comparators lie during ramp-up and with the string disconnected
	assign uv_mask = (st_q == LFS_SOFTSTART) || !drv_q.dimming_switch_drive ||
		((st_q == LFS_RUN) && (tmr_q < LFS_TW'(STARTUP_MASK_CYCLES)));

	// per-counter qualifying condition and trip level
	always_comb begin
		cond[LFS_CH_ILIM] = active && flt.ls_ilim;
		cond[LFS_CH_OC] = active && flt.out_oc;
		cond[LFS_CH_SHORT] = active && flt.led_short && !uv_mask;
		cond[LFS_CH_STR] = active && flt.str_short && drv_q.dimming_switch_drive;
		thr[LFS_CH_ILIM] = LFS_ILIM_CYCLES + 7'h01;
		thr[LFS_CH_OC] = oc_cycles(cfg_q[LFS_CFG_OCF +: 2]);
		thr[LFS_CH_SHORT] = LFS_SHORT_CYCLES;
		thr[LFS_CH_STR] = LFS_STR_CYCLES;
	end

	// switching-cycle persistence counters, cleared when the condition drops
	genvar gi;
	generate
		for (gi = 0; gi < LFS_NCH; gi++) begin : g_cnt
			logic [LFS_CW-1:0] cnt_q, cnt_d;
			always_comb begin
				cnt_d = cnt_q;
				if (!cond[gi]) begin
					cnt_d = '0;
				end else if (sw_cycle && (cnt_q != thr[gi])) begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			assign trip[gi] = cond[gi] && (cnt_q >= thr[gi]);
			always_ff @(posedge clk) begin
				if (!rst_b) begin
					cnt_q <= '0;
				end else if (ce) begin
					cnt_q <= cnt_d;
				end
			end
		end
	endgenerate

	assign hic_trip = trip[LFS_CH_ILIM] | trip[LFS_CH_OC] | trip[LFS_CH_STR] |
		(cfg_q[LFS_CFG_OVB] && ovstop && active);
	assign oneout_stop = cfg_q[LFS_CFG_ONEOUT] && trip[LFS_CH_SHORT];

	// sequencer, drives and fault flags
	always_comb begin
		st_d = st_q;
		tmr_d = (tmr_q == '1) ? tmr_q : tmr_q + 1'b1;
		unique case (st_q)
			LFS_STANDBY: begin
				if (en_pwm && !sup) begin
					st_d = LFS_SOFTSTART;
				end
			end
			LFS_SOFTSTART: begin
				if (hic_trip) begin
					st_d = LFS_HICCUP;
				end else if (tmr_q >= LFS_TW'(SOFTSTART_CYCLES - 1)) begin
					st_d = LFS_RUN;
				end
			end
			LFS_RUN: begin
				if (hic_trip) begin
					st_d = LFS_HICCUP;
				end
			end
			LFS_HICCUP: begin
				if (tmr_q >= LFS_TW'(HICCUP_CYCLES - 1)) begin
					st_d = LFS_SOFTSTART;
				end
			end
		endcase
		// supply faults and enable low win; restart comes back through standby
		if (!en_pwm || sup) begin
			st_d = LFS_STANDBY;
		end
		if (st_d != st_q) begin
			tmr_d = '0;
		end
		// latched until reset or a one written to the clear bit; set wins
		hbf_d = (hbf_q && !hbf_clr) || (flt.hb_fault && drv_q.beam_select_drive);
		// hysteretic mode: switching pauses while the output is above the trip
		sw_on = ((st_d == LFS_SOFTSTART) || (st_d == LFS_RUN)) && !ovstop && !oneout_stop;
		drv_d.low_side_drive = sw_on;
		drv_d.high_side_drive = sw_on;
		// one-out-all-out leaves the string connected: opening it would mask the short and release the stop
		drv_d.dimming_switch_drive = ((st_d == LFS_SOFTSTART) || (st_d == LFS_RUN)) && en_pwm &&
			!flt.dim_uv;
		drv_d.beam_select_drive = ((st_d == LFS_SOFTSTART) || (st_d == LFS_RUN)) && beam_request &&
			!hbf_d && !flt.gate_drive_supply_uv;
		drv_d.gate_drive_supply_en = !flt.thermal_shutdown_level;
		lowb_d = !beam_request || hbf_d;
		osc_d = flt.frequency_set_pin_fault;
		ff_any = sup | trip[LFS_CH_ILIM] | trip[LFS_CH_OC] | trip[LFS_CH_STR] | ovstop | hbf_d |
			flt.frequency_set_pin_fault | (trip[LFS_CH_SHORT] && cfg_q[LFS_CFG_LEDSC]) | (st_d == LFS_HICCUP);
		ff1_n_d = !ff_any;
		ff2_n_d = !(ff_any && cfg_q[LFS_CFG_FF2]);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_q <= LFS_STANDBY;
			tmr_q <= '0;
			uvf_q <= '0;
			hbf_q <= 1'b0;
			drv_q <= '0;
			lowb_q <= 1'b1;
			osc_q <= 1'b0;
			ff1_n_q <= 1'b1;
			ff2_n_q <= 1'b1;
		end else if (ce) begin
			st_q <= st_d;
			tmr_q <= tmr_d;
			uvf_q <= uvf_d;
			hbf_q <= hbf_d;
			drv_q <= drv_d;
			lowb_q <= lowb_d;
			osc_q <= osc_d;
			ff1_n_q <= ff1_n_d;
			ff2_n_q <= ff2_n_d;
		end
	end

	// register bus: writes commit once both address and data are held
	logic aw_have_q, aw_have_d, w_have_q, w_have_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	logic [LFS_AW-1:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d, wm;
	logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;

	assign evt = flt & ~prev_q;
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;

	always_comb begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		cfg_d = cfg_q;
		mask_d = mask_q;
		hbf_clr = 1'b0;
		stat_d = stat_q;
		wm = lane_mask(s_axi_wstrb);
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_d = 1'b1;
			wdata_d = s_axi_wdata & wm;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (aw_have_q && w_have_q) begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = LFS_RESP_OKAY;
			// byte lanes were folded into the held data; masked-off bits are written as zero, which leaves status bits set
			unique case ({awaddr_q[LFS_AW-1:2], 2'h0})
				LFS_OFS_CFG: cfg_d = wdata_q[LFS_CFG_W-1:0];
				LFS_OFS_STATUS: stat_d = stat_q & ~wdata_q[LFS_NFLT-1:0];
				LFS_OFS_MASK: mask_d = wdata_q[LFS_NFLT-1:0];
				LFS_OFS_DIAG: hbf_clr = wdata_q[LFS_DIAG_HBF];
				LFS_OFS_LIVE: bresp_d = LFS_RESP_OKAY;
				default: bresp_d = LFS_RESP_SLVERR;
			endcase
		end
		// new events override a clear arriving in the same cycle
		stat_d = stat_d | evt;
		if (s_axi_rvalid && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d = LFS_RESP_OKAY;
			rdata_d = '0;
			unique case ({s_axi_araddr[LFS_AW-1:2], 2'h0})
				LFS_OFS_CFG: rdata_d[LFS_CFG_W-1:0] = cfg_q;
				LFS_OFS_STATUS: rdata_d[LFS_NFLT-1:0] = stat_q;
				LFS_OFS_MASK: rdata_d[LFS_NFLT-1:0] = mask_q;
				LFS_OFS_DIAG: rdata_d[LFS_DIAG_HBF] = hbf_q;
				LFS_OFS_LIVE: begin
					rdata_d[LFS_NFLT-1:0] = flt;
					rdata_d[LFS_LIVE_FF] = !ff1_n_q;
				end
				default: rresp_d = LFS_RESP_SLVERR;
			endcase
		end
		irq_d = |(stat_d & mask_d);
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= LFS_RESP_OKAY;
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= LFS_RESP_OKAY;
			cfg_q <= LFS_CFG_RST;
			mask_q <= '0;
			stat_q <= '0;
			prev_q <= '0;
			irq_q <= 1'b0;
		end else if (ce) begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			cfg_q <= cfg_d;
			mask_q <= mask_d;
			stat_q <= stat_d;
			prev_q <= flt;
			irq_q <= irq_d;
		end
	end

	// outputs
	assign drv = drv_q;
	assign primary_fault_flag_n = ff1_n_q;
	assign secondary_fault_flag_n = ff2_n_q;
	assign osc_default_sel = osc_q;
	assign low_beam_mode = lowb_q;
	assign linear_regulator_enable = cfg_q[LFS_CFG_LREG];
	assign irq = irq_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	// checks; frozen cycles are not judged, nor the first edge after a thaw,
	// where ce has already risen but the flops still held
	logic chk_ce_q;
	always_ff @(posedge clk) begin
		chk_ce_q <= ce;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b || !ce || !chk_ce_q);

	sequence s_all_off;
		!drv_q.low_side_drive && !drv_q.high_side_drive && !drv_q.dimming_switch_drive && !ff1_n_q;
	endsequence

	a_vin_ov_off: assert property (flt.vin_ov |=> s_all_off) else $error("input OV left drives on");
	a_internal_regulator_output_uv_off: assert property (flt.internal_regulator_output_uv |=> s_all_off) else $error("regulator UV left drives on");
	a_gate_drive_supply_beam_off: assert property (flt.gate_drive_supply_uv |=> s_all_off and !drv_q.beam_select_drive)
		else $error("drive supply UV left beam on");
	a_tsd_supply_off: assert property (flt.thermal_shutdown_level |=> !drv_q.gate_drive_supply_en && st_q == LFS_STANDBY)
		else $error("thermal fault left supply on");
	a_dim_uv_open: assert property (flt.dim_uv |=> !drv_q.dimming_switch_drive)
		else $error("dimming switch not opened");
	a_hbf_lowbeam: assert property (hbf_q |-> low_beam_mode && !drv_q.beam_select_drive && !ff1_n_q)
		else $error("high-beam fault not in low beam");
	a_frequency_set_pin_default: assert property (flt.frequency_set_pin_fault |=> osc_default_sel && !ff1_n_q)
		else $error("frequency pin fault not handled");
	a_en_standby: assert property (!en_pwm |=> st_q == LFS_STANDBY && !drv_q.low_side_drive)
		else $error("running with enable low");
	a_trip_hiccup: assert property (hic_trip && !sup && en_pwm |=> st_q == LFS_HICCUP ##0 s_all_off)
		else $error("trip did not enter hiccup");
	a_hiccup_hold: assert property ($rose(st_q == LFS_HICCUP) && en_pwm && !sup |->
		(st_q == LFS_HICCUP || !en_pwm || sup)[*2]) else $error("hiccup ended early");
	a_ovb0_hyst: assert property (!cfg_q[LFS_CFG_OVB] && flt.out_ov && st_q == LFS_RUN && !sup && en_pwm
		&& !hic_trip |=> st_q == LFS_RUN && !drv_q.low_side_drive) else $error("hysteretic mode wrong");
endmodule
`default_nettype wire

/* hw/lfs_pkg.sv */
`default_nettype none
package lfs_pkg;
	// raw comparator levels from the analog front end
	typedef struct packed {
		logic vin_uv;
		logic vin_ov;
		logic internal_regulator_output_uv;
		logic gate_drive_supply_uv;
		logic ls_ilim;
		logic thermal_shutdown_level;
		logic out_ov;
		logic out_oc;
		logic led_short;
		logic dim_uv;
		logic open_led;
		logic hb_fault;
		logic frequency_set_pin_fault;
		logic str_short;
	} lfs_fault_type;

	// gate and supply enables towards the power stage
	typedef struct packed {
		logic gate_drive_supply_en;
		logic beam_select_drive;
		logic dimming_switch_drive;
		logic high_side_drive;
		logic low_side_drive;
	} lfs_drive_type;

	typedef enum logic [1:0] {LFS_STANDBY, LFS_SOFTSTART, LFS_RUN, LFS_HICCUP} lfs_state_type;

	localparam int LFS_NFLT = 14;
	localparam int LFS_AW = 5;
	localparam logic [LFS_AW-1:0] LFS_OFS_CFG = 5'h00;
	localparam logic [LFS_AW-1:0] LFS_OFS_STATUS = 5'h04;
	localparam logic [LFS_AW-1:0] LFS_OFS_MASK = 5'h08;
	localparam logic [LFS_AW-1:0] LFS_OFS_DIAG = 5'h0c;
	localparam logic [LFS_AW-1:0] LFS_OFS_LIVE = 5'h10;
	localparam logic [1:0] LFS_RESP_OKAY = 2'h0;
	localparam logic [1:0] LFS_RESP_SLVERR = 2'h2;

	// configuration, diagnostic and live register fields
	localparam int LFS_CFG_W = 7;
	localparam logic [LFS_CFG_W-1:0] LFS_CFG_RST = 7'h00;
	localparam int LFS_CFG_OVB = 0;
	localparam int LFS_CFG_ONEOUT = 1;
	localparam int LFS_CFG_OCF = 2;
	localparam int LFS_CFG_FF2 = 4;
	localparam int LFS_CFG_LREG = 5;
	localparam int LFS_CFG_LEDSC = 6;
	localparam int LFS_DIAG_HBF = 5;
	localparam int LFS_LIVE_FF = 16;

	// switching-cycle counters
	localparam int LFS_CW = 7;
	localparam int LFS_NCH = 4;
	localparam int LFS_CH_ILIM = 0;
	localparam int LFS_CH_OC = 1;
	localparam int LFS_CH_SHORT = 2;
	localparam int LFS_CH_STR = 3;
	localparam logic [LFS_CW-1:0] LFS_ILIM_CYCLES = 7'h40;
	localparam logic [LFS_CW-1:0] LFS_SHORT_CYCLES = 7'h1e;
	localparam logic [LFS_CW-1:0] LFS_STR_CYCLES = 7'h02;
	localparam logic [LFS_CW-1:0] LFS_OC_C0 = 7'h02;
	localparam logic [LFS_CW-1:0] LFS_OC_C1 = 7'h04;
	localparam logic [LFS_CW-1:0] LFS_OC_C2 = 7'h08;
	localparam logic [LFS_CW-1:0] LFS_OC_C3 = 7'h10;

	// timing
	localparam int LFS_CLK_HZ = 20_000_000;
	localparam int LFS_STARTUP_MASK_MS = 50;
	localparam int LFS_STARTUP_MASK_CYCLES = LFS_STARTUP_MASK_MS * (LFS_CLK_HZ / 1000);
	localparam int LFS_TW = 20;
	localparam int LFS_UVW = 12;
	localparam int LFS_FREQUENCY_SET_PIN_DEFAULT_KHZ = 350;
endpackage
`default_nettype wire

/* verification/lfs_stage_model.sv */
`default_nettype none
module lfs_stage_model import lfs_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// bench fault commands and stage enables
	input wire lfs_fault_type inj,
	input wire lfs_drive_type drv,
	// comparators and oscillator
	output lfs_fault_type flt,
	output logic sw_cycle
);
	logic [1:0] div_q;

	// the drive rail sags once its enable drops, so the comparator sees it
	always_comb begin
		flt = inj;
		flt.gate_drive_supply_uv = inj.gate_drive_supply_uv | (rst_b & !drv.gate_drive_supply_en);
	end

	// oscillator runs free, one pulse every four clocks
	always_ff @(posedge clk) begin
		if (!rst_b)
			div_q <= 2'h0;
		else
			div_q <= div_q + 2'h1;
	end
	assign sw_cycle = div_q == 2'h3;
endmodule
`default_nettype wire

/* verification/lfs_supervisor_tb_top.sv */
`default_nettype none
module lfs_supervisor_tb_top import lfs_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0, rst_b = 1'b0, en_pwm = 1'b0, beam_request = 1'b0, sw_cycle;
	lfs_fault_type inj = '0, flt;
	lfs_drive_type drv;
	logic pf_n, sf_n, osc_sel, low_beam, lre, irq;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata = 32'h0, rdata, rd;
	logic [1:0] bresp, rresp, rs;
	logic ce = 1'b1;
	logic [3:0] wstrb = 4'hf;
	int failures = 0, n_tests = 0;

	always #25 clk = ~clk;

	lfs_stage_model lfs_stage_model_i(.clk(clk), .rst_b(rst_b), .inj(inj), .drv(drv), .flt(flt),
		.sw_cycle(sw_cycle));

	// short counts keep hiccup and start-up within a quick run
	lfs_supervisor #(.HICCUP_CYCLES(20), .SOFTSTART_CYCLES(8), .STARTUP_MASK_CYCLES(16),
		.UV_FILTER_CYCLES(3)) lfs_supervisor_i(.clk(clk), .rst_b(rst_b), .ce(ce), .flt(flt),
		.en_pwm(en_pwm), .beam_request(beam_request), .sw_cycle(sw_cycle), .drv(drv),
		.primary_fault_flag_n(pf_n), .secondary_fault_flag_n(sf_n), .osc_default_sel(osc_sel),
		.low_beam_mode(low_beam), .linear_regulator_enable(lre), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	task automatic results;
		$display("tests %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic inject(input int i, input logic v);
		@(posedge clk);
		inj[i] <= v;
	endtask

	// address and data offered together, each dropped once taken
	task automatic axw(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge clk);
			if (!ta && awready) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if (!tw && wready) begin
				tw = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (!bvalid) @(posedge clk);
		r = bresp;
		bready <= 1'b0;
		#1;
	endtask

	task automatic axr(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		while (!rvalid) @(posedge clk);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		#1;
	endtask

	// bounded wait for switching, then past soft-start and the start-up mask
	task automatic until_on;
		for (int k = 0; k < 200 && drv.low_side_drive !== 1'b1; k++) @(posedge clk);
		cyc(30);
		chk("restart", 1, drv.low_side_drive);
	endtask

	// switching pulses seen until the flag or the low-side drive drops
	task automatic count(input bit fl, output int n);
		n = 0;
		for (int k = 0; k < 1000 && (fl ? pf_n : drv.low_side_drive) === 1'b1; k++) begin
			@(posedge clk);
			n += int'(sw_cycle);
		end
	endtask

	task automatic trip(input int i, input int e);
		int n;
		inject(i, 1'b1);
		count(1'b0, n);
		chk("trip count", e, n);
		cyc(12);
		chk("hiccup flag", 0, pf_n);
		chk("hiccup drive", 0, drv.low_side_drive);
		inject(i, 1'b0);
		until_on;
	endtask

	task automatic t_start;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		beam_request <= 1'b1;
		#1;
		chk("reset drv", 0, drv);
		chk("reset flag", 1, pf_n);
		cyc(10);
		chk("no enable", 0, drv.low_side_drive);
		@(posedge clk);
		en_pwm <= 1'b1;
		until_on;
		chk("dim on", 1, drv.dimming_switch_drive);
		chk("beam on", 1, drv.beam_select_drive);
	endtask

	task automatic t_regs;
		axr(LFS_OFS_CFG, rd, rs);
		chk("cfg reset", 32'(LFS_CFG_RST), rd);
		axr(5'h14, rd, rs);
		chk("unmapped read", LFS_RESP_SLVERR, rs);
		axw(5'h18, 32'h1, rs);
		chk("unmapped write", LFS_RESP_SLVERR, rs);
		axw(LFS_OFS_CFG, 32'h30, rs);
		chk("bresp", LFS_RESP_OKAY, rs);
		cyc(2);
		chk("lre", 1, lre);
		inject(1, 1'b1);
		cyc(3);
		chk("osc default", 1, osc_sel);
		chk("frequency_set_pin flag", 0, pf_n);
		chk("ff2 flag", 0, sf_n);
		axr(LFS_OFS_LIVE, rd, rs);
		chk("live", (32'h1 << LFS_LIVE_FF) | 32'h2, rd);
		chk("irq masked", 0, irq);
		axw(LFS_OFS_MASK, 32'h2, rs);
		cyc(2);
		chk("irq on", 1, irq);
		inject(1, 1'b0);
		cyc(3);
		chk("irq sticky", 1, irq);
		// a clear with every byte lane off must leave the status alone
		@(posedge clk);
		wstrb <= 4'h0;
		axw(LFS_OFS_STATUS, 32'h2, rs);
		cyc(2);
		chk("irq strobe off", 1, irq);
		@(posedge clk);
		wstrb <= 4'hf;
		axw(LFS_OFS_STATUS, 32'h2, rs);
		cyc(2);
		chk("irq clear", 0, irq);
		inject(2, 1'b1);
		cyc(3);
		chk("low beam", 1, low_beam);
		chk("hb flag", 0, pf_n);
		inject(2, 1'b0);
		cyc(3);
		chk("hb latched", 1, low_beam);
		axr(LFS_OFS_DIAG, rd, rs);
		chk("hb status", 1, rd[LFS_DIAG_HBF]);
		axw(LFS_OFS_DIAG, 32'h20, rs);
		cyc(3);
		chk("hb cleared", 0, low_beam);
	endtask

	task automatic t_faults;
		int ids[4] = '{12, 11, 10, 8};
		int n;
		foreach (ids[j]) begin
			inject(ids[j], 1'b1);
			cyc(3);
			chk("supply off", 0, {drv.low_side_drive, drv.high_side_drive, drv.dimming_switch_drive});
			chk("supply flag", 0, pf_n);
			if (ids[j] == 10)
				chk("beam off", 0, drv.beam_select_drive);
			if (ids[j] == 8)
				chk("rail off", 0, drv.gate_drive_supply_en);
			inject(ids[j], 1'b0);
			until_on;
		end
		// a fault arriving while frozen takes effect only once ce returns
		@(posedge clk);
		ce <= 1'b0;
		inject(12, 1'b1);
		cyc(3);
		chk("ce freeze", 1, drv.low_side_drive);
		chk("ce freeze flag", 1, pf_n);
		@(posedge clk);
		ce <= 1'b1;
		cyc(2);
		chk("ce resume", 0, drv.low_side_drive);
		chk("ce resume flag", 0, pf_n);
		inject(12, 1'b0);
		until_on;
		inject(13, 1'b1);
		cyc(2);
		chk("uv filter", 1, drv.low_side_drive);
		cyc(6);
		chk("uv off", 0, drv.low_side_drive);
		chk("uv flag", 0, pf_n);
		inject(13, 1'b0);
		until_on;
		inject(4, 1'b1);
		cyc(3);
		chk("dim uv open", 0, drv.dimming_switch_drive);
		chk("dim uv switching", 1, drv.low_side_drive);
		inject(4, 1'b0);
		cyc(3);
		chk("dim back", 1, drv.dimming_switch_drive);
		for (int m = 0; m < 4; m++) begin
			axw(LFS_OFS_CFG, 32'(m % 2), rs);
			inject(m < 2 ? 7 : 3, 1'b1);
			cyc(3);
			chk("ov stop", 0, drv.low_side_drive);
			chk("ov flag", 0, pf_n);
			chk("ff2 off", 1, sf_n);
			chk("ov dim", 32'(1 - m % 2), drv.dimming_switch_drive);
			inject(m < 2 ? 7 : 3, 1'b0);
			until_on;
		end
		axw(LFS_OFS_CFG, 32'h42, rs);
		inject(5, 1'b1);
		count(1'b1, n);
		chk("short count", 30, n);
		cyc(3);
		chk("one out all out", 0, drv.low_side_drive);
		inject(5, 1'b0);
		until_on;
	endtask

	task automatic t_counted;
		trip(9, 65);
		trip(0, 2);
		for (int c = 0; c < 4; c++) begin
			axw(LFS_OFS_CFG, 32'(c << LFS_CFG_OCF), rs);
			trip(6, 2 << c);
		end
	endtask

	// main sequence
	initial begin
		t_start;
		t_regs;
		t_faults;
		t_counted;
		results;
	end

	// hang guard, well above the expected run length
	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		$display("[ERR] watchdog expected done seen hang");
		results;
	end
endmodule
`default_nettype wire
